// [include/clkdiv_defines.vh]
// Function
// R1 - Four dividers, one shared register layout
// R2 - Enable bit 15 gates divider, reset on
// R3 - Ratio field value plus one divides
// R4 - Reset ratios /1, /1, /2, /2
// R5 - Software keeps second ratio twice first
// R6 - Reserved bits read zero, ignore writes
// R7 - Aux divider register independent of chain
// R8 - Aux clock from reference, not PLL
// R9 - Aux enable bit 15, set after reset
// R10 - Aux ratio resets to divide-by-8
// R11 - Aux ratio uses value-plus-one encoding
// R12 - PLL enable selects PLL or reference source
// R13 - Software never disables first two post-scalers
`ifndef CLKDIV_DEFINES_VH
`define CLKDIV_DEFINES_VH

// Register byte addresses
`define ADDR_PLL_CONTROL       32'h01B7C100
`define ADDR_PRESCALER_DIV     32'h01B7C114
`define ADDR_POST_DIV_ONE      32'h01B7C118
`define ADDR_POST_DIV_TWO      32'h01B7C11C
`define ADDR_POST_DIV_THREE    32'h01B7C120
`define ADDR_OSC_DIV           32'h01B7C124

// Field layout
`define DIV_EN_BIT             15
`define DIV_RATIO_MSB          4
`define DIV_RATIO_LSB          0
`define PLL_EN_BIT             0

// Reset values
`define RST_DIV_EN             1'h1
`define RST_PRESCALER_RATIO    5'h00
`define RST_POST_ONE_RATIO     5'h00
`define RST_POST_TWO_RATIO     5'h01
`define RST_POST_THREE_RATIO   5'h01
`define RST_OSC_RATIO          5'h07
`define RST_PLL_EN             1'h0

// Bus encodings
`define HTRANS_NONSEQ_BIT      1
`define HRESP_OKAY             1'h0
`define WORD_ZERO              32'h00000000
`define RATIO_ZERO             5'h00

`endif

// [design/clk_ratio_divider.v]
`timescale 1ns/100ps
`include "clkdiv_defines.vh"

// Divides a stream of source ticks by ratio plus one
module clk_ratio_divider (
    // Clock and reset
    input  wire       clk_sys_i,
    input  wire       rst_b_i,
    // Control
    input  wire       enable_i,
    input  wire [4:0] ratio_i,
    // Source and result
    input  wire       src_tick_i,
    output wire       div_tick_o
);

    reg [4:0] count_q;
    reg [4:0] count_d;
    reg       tick_q;
    reg       tick_d;

    // Count source ticks; one output pulse per ratio+1 ticks
    always @* begin
        count_d = count_q;
        tick_d  = 1'b0;
        if (!enable_i) begin
            count_d = `RATIO_ZERO; // R2
        end else if (src_tick_i) begin
            tick_d = (count_q == `RATIO_ZERO); // R3
            // Ratio shrinking below count restarts cleanly, no long runaway period
            if (count_q >= ratio_i) begin
                count_d = `RATIO_ZERO;
            end else begin
                count_d = count_q + 5'h01;
            end
        end
    end

    always @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            count_q <= `RATIO_ZERO;
            tick_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            tick_q  <= tick_d;
        end
    end

    assign div_tick_o = tick_q;

endmodule

// [design/pll_clock_divider_bank.v]
`timescale 1ns/100ps
`include "clkdiv_defines.vh"

// Divider bank around the PLL, configured over AHB-Lite
module pll_clock_divider_bank (
    // Clock and reset
    input  wire        clk_sys_i,
    input  wire        rst_b_i,
    // AHB-Lite slave
    input  wire        hsel_i,
    input  wire [31:0] haddr_i,
    input  wire [1:0]  htrans_i,
    input  wire        hwrite_i,
    input  wire [2:0]  hsize_i,
    input  wire [31:0] hwdata_i,
    input  wire        hready_i,
    output wire [31:0] hrdata_o,
    output wire        hreadyout_o,
    output wire        hresp_o,
    // PLL side
    input  wire        pll_out_tick_i,
    output wire        pll_ref_tick_o,
    output wire        pll_enable_o,
    // Divided clock enables
    output wire        system_clock_one_o,
    output wire        system_clock_two_o,
    output wire        system_clock_three_o,
    output wire        aux_clock_output_o
);

    // One-hot bus states
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_WRITE = 3'b010;
    localparam [2:0] ST_READ  = 3'b100;

    reg [2:0]  state_q;
    reg [2:0]  state_d;
    reg [31:0] addr_q;
    reg [31:0] hrdata_q;
    reg [31:0] rd_word;

    // Divider fields: index 0 prescaler, 1..3 post-scalers, 4 aux
    reg        div_en_q [0:4];
    reg [4:0]  div_ratio_q [0:4];
    reg        pll_en_q;
    integer    i;

    wire       addr_phase;
    wire       post_src;
    wire [4:0] div_tick;

    // Reserved bits come back as zero
    function [31:0] pack_div;
        input       en;
        input [4:0] ratio;
        begin
            pack_div = `WORD_ZERO; // R6
            pack_div[`DIV_EN_BIT] = en;
            pack_div[`DIV_RATIO_MSB:`DIV_RATIO_LSB] = ratio;
        end
    endfunction

    // Map a byte address to divider index, 7 when none
    function [2:0] div_index;
        input [31:0] addr;
        begin
            case (addr)
                `ADDR_PRESCALER_DIV:  div_index = 3'h0; // R1
                `ADDR_POST_DIV_ONE:   div_index = 3'h1;
                `ADDR_POST_DIV_TWO:   div_index = 3'h2;
                `ADDR_POST_DIV_THREE: div_index = 3'h3;
                `ADDR_OSC_DIV:        div_index = 3'h4; // R7
                default:              div_index = 3'h7;
            endcase
        end
    endfunction

    assign addr_phase = hsel_i && hready_i && htrans_i[`HTRANS_NONSEQ_BIT];

    // Bus sequencing; reads take one wait state so data leaves a flip-flop
    always @* begin
        state_d = ST_IDLE;
        case (state_q)
            ST_READ: begin
                state_d = ST_IDLE;
            end
            ST_IDLE, ST_WRITE: begin
                if (addr_phase) begin
                    state_d = hwrite_i ? ST_WRITE : ST_READ;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // Read multiplexer
    always @* begin
        rd_word = `WORD_ZERO;
        if (addr_q == `ADDR_PLL_CONTROL) begin
            rd_word[`PLL_EN_BIT] = pll_en_q;
        end else if (div_index(addr_q) != 3'h7) begin
            rd_word = pack_div(div_en_q[div_index(addr_q)],
                               div_ratio_q[div_index(addr_q)]);
        end
    end

    // Bus state, address capture and read data
    always @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            state_q  <= ST_IDLE;
            addr_q   <= `WORD_ZERO;
            hrdata_q <= `WORD_ZERO;
        end else begin
            state_q <= state_d;
            if (addr_phase && (state_q != ST_READ)) begin
                addr_q <= haddr_i;
            end
            if (state_q == ST_READ) begin
                hrdata_q <= rd_word;
            end
        end
    end

    // Control registers; writes land in the data phase
    always @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            for (i = 0; i < 5; i = i + 1) begin
                div_en_q[i] <= `RST_DIV_EN; // R2 R9
            end
            div_ratio_q[0] <= `RST_PRESCALER_RATIO; // R4
            div_ratio_q[1] <= `RST_POST_ONE_RATIO;
            div_ratio_q[2] <= `RST_POST_TWO_RATIO;
            div_ratio_q[3] <= `RST_POST_THREE_RATIO;
            div_ratio_q[4] <= `RST_OSC_RATIO; // R10
            pll_en_q       <= `RST_PLL_EN;
        end else if (state_q == ST_WRITE) begin
            if (addr_q == `ADDR_PLL_CONTROL) begin
                pll_en_q <= hwdata_i[`PLL_EN_BIT];
            end
            for (i = 0; i < 5; i = i + 1) begin
                if (div_index(addr_q) == i[2:0]) begin
                    // Only bit 15 and bits 4:0 are stored
                    div_en_q[i]    <= hwdata_i[`DIV_EN_BIT]; // R6
                    div_ratio_q[i] <= hwdata_i[`DIV_RATIO_MSB:`DIV_RATIO_LSB];
                end
            end
        end
    end

    // Post-scalers count PLL ticks, or reference cycles in bypass
    assign post_src = pll_en_q ? pll_out_tick_i : 1'b1; // R12

    // Prescaler runs from the reference; its output feeds the PLL
    clk_ratio_divider u_prescaler (
        .clk_sys_i  (clk_sys_i),
        .rst_b_i    (rst_b_i),
        .enable_i   (div_en_q[0] && pll_en_q), // R12
        .ratio_i    (div_ratio_q[0]),
        .src_tick_i (1'b1),
        .div_tick_o (div_tick[0])
    );

    clk_ratio_divider u_post_one (
        .clk_sys_i  (clk_sys_i),
        .rst_b_i    (rst_b_i),
        .enable_i   (div_en_q[1]),
        .ratio_i    (div_ratio_q[1]),
        .src_tick_i (post_src),
        .div_tick_o (div_tick[1])
    );

    clk_ratio_divider u_post_two (
        .clk_sys_i  (clk_sys_i),
        .rst_b_i    (rst_b_i),
        .enable_i   (div_en_q[2]),
        .ratio_i    (div_ratio_q[2]),
        .src_tick_i (post_src),
        .div_tick_o (div_tick[2])
    );

    clk_ratio_divider u_post_three (
        .clk_sys_i  (clk_sys_i),
        .rst_b_i    (rst_b_i),
        .enable_i   (div_en_q[3]),
        .ratio_i    (div_ratio_q[3]),
        .src_tick_i (post_src),
        .div_tick_o (div_tick[3])
    );

    // Aux divider never sees the PLL, enabled or not
    clk_ratio_divider u_aux (
        .clk_sys_i  (clk_sys_i),
        .rst_b_i    (rst_b_i),
        .enable_i   (div_en_q[4]), // R9
        .ratio_i    (div_ratio_q[4]), // R11
        .src_tick_i (1'b1), // R8
        .div_tick_o (div_tick[4])
    );

    // Outputs
    assign hrdata_o             = hrdata_q;
    assign hreadyout_o          = (state_q != ST_READ);
    assign hresp_o              = `HRESP_OKAY;
    assign pll_ref_tick_o       = div_tick[0];
    assign pll_enable_o         = pll_en_q;
    assign system_clock_one_o   = div_tick[1];
    assign system_clock_two_o   = div_tick[2];
    assign system_clock_three_o = div_tick[3];
    assign aux_clock_output_o   = div_tick[4];

endmodule

// [tb/clkdiv_chk_sva.sv]
`timescale 1ns/100ps
// Port-level checks of the divider bank
module clkdiv_chk (
    input logic        clk_sys_i,
    input logic        rst_b_i,
    input logic        hsel_i,
    input logic [1:0]  htrans_i,
    input logic        hwrite_i,
    input logic        hready_i,
    input logic [31:0] hrdata_o,
    input logic        hreadyout_o,
    input logic        hresp_o,
    input logic        pll_out_tick_i,
    input logic        pll_ref_tick_o,
    input logic        pll_enable_o,
    input logic        system_clock_one_o,
    input logic        system_clock_two_o,
    input logic        aux_clock_output_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    // Transfer accepted this edge
    wire req = hsel_i && hready_i && htrans_i[1];

    reset_clear_a: assert property (disable iff (1'b0) !rst_b_i |=>
        !pll_enable_o && !aux_clock_output_o && hrdata_o == 32'h0 && hreadyout_o)
        else $error("outputs not cleared by reset");
    aux_reset_div_a: assert property ($rose(rst_b_i) |->
        ##[0:3] aux_clock_output_o ##1 !aux_clock_output_o [*7] ##1 aux_clock_output_o)
        else $error("aux divider not dividing by 8 after reset");
    two_reset_div_a: assert property ($rose(rst_b_i) |->
        ##[0:3] system_clock_two_o ##1 !system_clock_two_o ##1 system_clock_two_o)
        else $error("second post divider not dividing by 2 after reset");
    one_reset_div_a: assert property ($rose(rst_b_i) |-> ##[1:3] system_clock_one_o [*4])
        else $error("first post divider not dividing by 1 after reset");
    ref_silent_a: assert property (!pll_enable_o [*2] |-> !pll_ref_tick_o)
        else $error("prescaler output while PLL bypassed");
    post_silent_a: assert property ((pll_enable_o && !pll_out_tick_i) [*3] |->
        !system_clock_one_o && !system_clock_two_o)
        else $error("post divider pulse without PLL tick");
    read_wait_a: assert property (req && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o && !hresp_o)
        else $error("read data phase timing wrong");
    write_ready_a: assert property (req && hwrite_i |=> hreadyout_o && !hresp_o)
        else $error("write data phase stalled");
endmodule

bind pll_clock_divider_bank clkdiv_chk u_chk (
    .clk_sys_i, .rst_b_i, .hsel_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o,
    .hresp_o, .pll_out_tick_i, .pll_ref_tick_o, .pll_enable_o, .system_clock_one_o,
    .system_clock_two_o, .aux_clock_output_o);

// [tb/pll_clock_divider_bank_tb.sv]
`timescale 1ns/100ps
module pll_clock_divider_bank_tb;
    logic        clk_sys_i, rst_b_i, hsel_i, hwrite_i, pll_out_tick_i, rd_ph;
    logic        hreadyout_o, hresp_o, pll_enable_o;
    logic [1:0]  htrans_i, tc;
    logic [4:0]  outs, r;
    logic [31:0] haddr_i, hwdata_i, hrdata_o, seed, wd;
    logic [31:0] exp_q [$];
    int          num_errors, checks, pc [5];
    logic [31:0] adr [5] = '{32'h01B7C114, 32'h01B7C118, 32'h01B7C11C, 32'h01B7C120,
                             32'h01B7C124};
    logic [31:0] rst_v [5] = '{32'h00008000, 32'h00008000, 32'h00008001, 32'h00008001,
                               32'h00008007};

    pll_clock_divider_bank dut (
        .clk_sys_i, .rst_b_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2),
        .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o, .hresp_o, .pll_out_tick_i,
        .pll_ref_tick_o(outs[4]), .pll_enable_o, .system_clock_one_o(outs[3]),
        .system_clock_two_o(outs[2]), .system_clock_three_o(outs[1]),
        .aux_clock_output_o(outs[0]));

    // 20 MHz reference
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Single word transfer; holds each phase until hready is seen high
    task automatic xfer(input logic wr, input logic [31:0] a, d, e);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= wr;
        do @(posedge clk_sys_i); while (!hreadyout_o);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        if (!wr) exp_q.push_back(e);
        do @(posedge clk_sys_i); while (!hreadyout_o);
    endtask

    // Settle after a ratio change, then count pulses on every output
    task automatic win(input int n, input int e [5]);
        pc = '{default: 0};
        repeat (40) @(posedge clk_sys_i);
        repeat (n) begin
            @(posedge clk_sys_i);
            foreach (pc[i]) pc[i] += outs[i];
        end
        foreach (pc[i]) chk(pc[i], e[i]);
    endtask

    // Reset pulse of four cycles, then every default read back
    task automatic reset_and_read();
        rst_b_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        // Idle long enough for the reset pulse patterns to show
        repeat (20) @(posedge clk_sys_i);
        foreach (adr[i]) xfer(1'b0, adr[i], 0, rst_v[i]);
        xfer(1'b0, 32'h01B7C100, 0, 0);
    endtask

    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Read results matched to the oldest noted expectation
    always @(posedge clk_sys_i) begin
        if (rd_ph && hreadyout_o) chk(hrdata_o, exp_q.pop_front());
        if (hreadyout_o) rd_ph <= hsel_i && htrans_i[1] && !hwrite_i;
    end

    // PLL output tick every fourth cycle, so gaps of three exist
    always @(posedge clk_sys_i) begin
        tc <= tc + 2'h1;
        pll_out_tick_i <= (tc == 2'h3);
    end

    initial begin
        {hsel_i, hwrite_i, pll_out_tick_i, rd_ph} = '0;
        {htrans_i, tc, haddr_i, hwdata_i} = '0;
        seed = 32'h51C5C325;
        reset_and_read();
        // Post one at /16 so post two at /32 stays twice as slow
        foreach (adr[i]) begin
            wd = (i == 1) ? 32'hFFFFFFEF : 32'hFFFFFFFF;
            xfer(1'b1, adr[i], wd, 0);
            xfer(1'b0, adr[i], 0, wd & 32'h0000801F);
        end
        xfer(1'b1, 32'h01B7C128, 32'hFFFFFFFF, 0);
        xfer(1'b0, 32'h01B7C128, 0, 0);
        // Random ratios; window of four periods is phase independent
        repeat (4) begin
            seed = lfsr(seed);
            r = {1'b0, seed[3:0]};
            foreach (adr[i]) begin
                wd = {16'h0000, 11'h400, r};
                if (i == 2) wd[4:0] = {r[3:0], 1'b1};
                xfer(1'b1, adr[i], wd, 0);
            end
            win((r + 1) * 4, '{4, 4, 2, 4, 0});
        end
        // PLL on: ticks every fourth cycle feed the post dividers
        xfer(1'b1, 32'h01B7C100, 32'h00000001, 0);
        foreach (adr[i]) xfer(1'b1, adr[i], (i == 2) ? 32'h00008003 : 32'h00008001, 0);
        win(32, '{16, 4, 2, 4, 16});
        chk({31'h00000000, pll_enable_o}, 32'h00000001);
        xfer(1'b0, 32'h01B7C100, 0, 32'h00000001);
        // Post one and two stay on; only the others may stop
        xfer(1'b1, adr[0], 32'h00000001, 0);
        xfer(1'b1, adr[3], 32'h00000001, 0);
        xfer(1'b1, adr[4], 32'h00000001, 0);
        win(64, '{0, 0, 4, 8, 0});
        // Mid-run reset must restore every default
        reset_and_read();
        // Let the monitor take the last read before the verdict
        repeat (2) @(posedge clk_sys_i);
        summarize();
    end

    // Watchdog
    initial begin
        #2000000;
        num_errors++;
        summarize();
    end
endmodule
